//--- sccc_top.v
// configuration, framing, identifier, filter and indicator logic of the converter
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sccc_defs.vh"
module sccc_top #(
  parameter [31:0] LED_CYCLES = `SCCC_LED_MS * `SCCC_CLK_KHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire config_strap_n,
  input wire serial_tx_event,
  input wire serial_rx_event,
  input wire bus_tx_event,
  input wire bus_rx_event,
  input wire [31:0] rx_ident,
  input wire rx_ident_valid,
  input wire [7:0] rx_frame_info,
  input wire [7:0] mark_frame_byte,
  input wire mark_frame_valid,
  input wire mark_frame_start,
  output reg rx_accept,
  output reg rx_reject,
  output reg [1:0] conv_mode,
  output reg emit_info,
  output reg emit_ident,
  output reg [2:0] header_len,
  output reg [7:0] header_info,
  output reg ext_frame,
  output reg [31:0] tx_ident,
  output reg [31:0] serial_baud,
  output reg [31:0] bus_rate,
  output reg config_mode,
  output wire power_indicator,
  output wire serial_tx_indicator,
  output wire serial_rx_indicator,
  output wire bus_tx_indicator,
  output wire bus_rx_indicator
);
  // shadow (being edited) and active sets
  reg [5:0] sh_ctrl;
  reg [31:0] sh_baud;
  reg [31:0] sh_rate;
  reg [31:0] sh_txid;
  reg [31:0] sh_acc;
  reg [31:0] sh_mask;
  reg [7:0] sh_mark;
  reg [5:0] ctrl;
  reg [31:0] acceptance_code;
  reg [31:0] fmask;
  reg [31:0] fixed_id;
  reg [7:0] mark_cfg;
  reg stored;
  reg strap_s1;
  reg strap_s2;
  reg strap_done;
  reg [1:0] strap_wait;
  reg [31:0] mark_id;
  reg [3:0] mark_pos;
  wire [7:0] ident_byte_0;
  wire [7:0] ident_byte_1;
  wire [7:0] ident_byte_2;
  wire [7:0] ident_byte_3;
  wire [7:0] acceptance_byte_0;
  wire [7:0] acceptance_byte_1;
  wire [7:0] acceptance_byte_2;
  wire [7:0] acceptance_byte_3;
  wire [3:0] act_in;
  wire [3:0] act_led;
  wire acc_en;
  wire wr_en;
  wire [31:0] id_keep;
  wire [31:0] eff_mask;
  wire [3:0] mark_start;
  wire [3:0] mark_len;
  wire [31:0] next_mark_id;
  wire [31:0] pick_id;
  wire [4:0] mark_end;
  wire mark_hit;
  wire plain_mode;
  wire mark_mode;
  wire commit_en;
  wire rd_en;
  wire ctrl_ok;
  wire baud_ok;
  wire rate_ok;
  wire [31:0] id_diff;
  wire id_match;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign acc_en = psel & penable;
  assign wr_en = acc_en & pwrite & config_mode;
  assign power_indicator = presetn;
  assign commit_en = wr_en & (paddr == `SCCC_OFF_COMMIT) & pwdata[`SCCC_COMMIT_BIT];
  assign rd_en = psel & ~penable & ~pwrite;
  // refused values leave the shadow copy untouched
  assign ctrl_ok = (pwdata[`SCCC_CTRL_MODE_HI:`SCCC_CTRL_MODE_LO] != `SCCC_MODE_BAD);
  assign baud_ok = (pwdata >= `SCCC_BAUD_MIN) && (pwdata <= `SCCC_BAUD_MAX);
  assign rate_ok = (pwdata >= `SCCC_BUSRATE_MIN) && (pwdata <= `SCCC_BUSRATE_MAX);

  // identifier bytes, ident_byte_0 most significant
  assign ident_byte_0 = sh_txid[31:24];
  assign ident_byte_1 = sh_txid[23:16];
  assign ident_byte_2 = sh_txid[15:8];
  assign ident_byte_3 = sh_txid[7:0];
  assign acceptance_byte_0 = sh_acc[31:24];
  assign acceptance_byte_1 = sh_acc[23:16];
  assign acceptance_byte_2 = sh_acc[15:8];
  assign acceptance_byte_3 = sh_acc[7:0];

  // strap sync then one-shot capture after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 1'b1;
      strap_s2 <= 1'b1;
      strap_done <= 1'b0;
      strap_wait <= 2'h0;
      config_mode <= 1'b0;
    end else begin
      strap_s1 <= config_strap_n;
      strap_s2 <= strap_s1;
      // capture only once the strap has crossed both sync stages
      if (!strap_done) begin
        if (strap_wait == `SCCC_STRAP_WAIT) begin
          strap_done <= 1'b1;
          config_mode <= ~strap_s2;
        end else begin
          strap_wait <= strap_wait + 2'h1;
        end
      end
    end
  end

  // shadow registers, writable only while configuring
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ctrl <= `SCCC_CTRL_DEF;
      sh_baud <= `SCCC_BAUD_DEF;
      sh_rate <= `SCCC_BUSRATE_DEF;
      sh_txid <= 32'h00000000;
      sh_acc <= 32'h00000000;
      sh_mask <= 32'h00000000;
      sh_mark <= `SCCC_MARK_DEF;
    end else if (wr_en) begin
      case (paddr)
        `SCCC_OFF_CTRL: begin
          if (ctrl_ok) begin
            sh_ctrl <= pwdata[`SCCC_CTRL_CMASK:0];
          end
        end
        `SCCC_OFF_BAUD: begin
          if (baud_ok) begin
            sh_baud <= pwdata;
          end
        end
        `SCCC_OFF_BUSRATE: begin
          if (rate_ok) begin
            sh_rate <= pwdata;
          end
        end
        `SCCC_OFF_TXID: sh_txid <= pwdata;
        `SCCC_OFF_ACC: sh_acc <= pwdata;
        `SCCC_OFF_MASK: sh_mask <= pwdata;
        `SCCC_OFF_MARK: sh_mark <= pwdata[7:0];
        default: sh_ctrl <= sh_ctrl;
      endcase
    end
  end

  // commit copies shadow to the active set; defaults until then
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored <= 1'b0;
      ctrl <= `SCCC_CTRL_DEF;
      serial_baud <= `SCCC_BAUD_DEF;
      bus_rate <= `SCCC_BUSRATE_DEF;
      fixed_id <= 32'h00000000;
      acceptance_code <= 32'h00000000;
      fmask <= 32'h00000000;
      mark_cfg <= `SCCC_MARK_DEF;
    end else if (commit_en) begin
      stored <= 1'b1;
      ctrl <= sh_ctrl;
      serial_baud <= sh_baud;
      bus_rate <= sh_rate;
      fixed_id <= {ident_byte_0, ident_byte_1, ident_byte_2, ident_byte_3};
      acceptance_code <= {acceptance_byte_0, acceptance_byte_1,
                          acceptance_byte_2, acceptance_byte_3};
      fmask <= sh_mask;
      mark_cfg <= sh_mark;
    end
  end

  // register read back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `SCCC_OFF_CTRL: prdata <= {26'h0, sh_ctrl};
        `SCCC_OFF_BAUD: prdata <= sh_baud;
        `SCCC_OFF_BUSRATE: prdata <= sh_rate;
        `SCCC_OFF_TXID: prdata <= sh_txid;
        `SCCC_OFF_ACC: prdata <= sh_acc;
        `SCCC_OFF_MASK: prdata <= sh_mask;
        `SCCC_OFF_MARK: prdata <= {24'h000000, sh_mark};
        // status: strap captured, set stored, configuration mode
        `SCCC_OFF_STATUS: prdata <= {29'h0, strap_done, stored, config_mode};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // identifier truncation by frame type
  assign id_keep = ctrl[`SCCC_CTRL_EXT] ? `SCCC_EXT_MASK : `SCCC_STD_MASK;
  assign plain_mode = (ctrl[`SCCC_CTRL_MODE_HI:`SCCC_CTRL_MODE_LO] == `SCCC_MODE_PLAIN);
  assign mark_mode = (ctrl[`SCCC_CTRL_MODE_HI:`SCCC_CTRL_MODE_LO] == `SCCC_MODE_MARK);
  assign pick_id = mark_mode ? mark_id : fixed_id;
  // mask bit set means do not care; forced to zero without custom mask
  assign eff_mask = ctrl[`SCCC_CTRL_CMASK] ? fmask : 32'h00000000;
  // identifier compare, don't-care bits excluded
  assign id_diff = ((rx_ident & id_keep) ^ acceptance_code) & ~eff_mask;
  assign id_match = (id_diff == 32'h00000000);

  // address mark extraction: low nibble start offset, high nibble length
  assign mark_start = mark_cfg[`SCCC_MARK_START_HI:0];
  assign mark_len = mark_cfg[`SCCC_MARK_LEN_HI:`SCCC_MARK_LEN_LO];
  assign next_mark_id = {mark_id[23:0], mark_frame_byte};
  // window end kept one bit wider so start plus length cannot wrap
  assign mark_end = {1'b0, mark_start} + {1'b0, mark_len};
  assign mark_hit = (mark_pos >= mark_start) && ({1'b0, mark_pos} < mark_end);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_id <= 32'h00000000;
      mark_pos <= 4'h0;
    end else if (mark_frame_valid) begin
      if (mark_frame_start) begin
        mark_pos <= 4'h1;
        if (mark_start == 4'h0 && mark_len != 4'h0) begin
          mark_id <= {24'h000000, mark_frame_byte};
        end else begin
          mark_id <= 32'h00000000;
        end
      end else begin
        if (mark_pos != 4'hf) begin
          mark_pos <= mark_pos + 4'h1;
        end
        if (mark_hit) begin
          mark_id <= next_mark_id;
        end
      end
    end
  end

  // configuration outputs and receive filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_mode <= `SCCC_MODE_PLAIN;
      emit_info <= 1'b0;
      emit_ident <= 1'b0;
      header_len <= 3'h0;
      header_info <= 8'h00;
      ext_frame <= 1'b0;
      tx_ident <= 32'h00000000;
      rx_accept <= 1'b0;
      rx_reject <= 1'b0;
    end else begin
      conv_mode <= ctrl[`SCCC_CTRL_MODE_HI:`SCCC_CTRL_MODE_LO];
      emit_info <= plain_mode & ctrl[`SCCC_CTRL_INFO];
      emit_ident <= plain_mode & ctrl[`SCCC_CTRL_IDENT];
      header_len <= {2'h0, emit_info} + (emit_ident ? `SCCC_IDENT_BYTES : 3'h0);
      header_info <= rx_frame_info;
      ext_frame <= ctrl[`SCCC_CTRL_EXT];
      tx_ident <= pick_id & id_keep;
      rx_accept <= rx_ident_valid & id_match;
      rx_reject <= rx_ident_valid & ~id_match;
    end
  end

  // activity indicators: synchronised, stretched, retriggered
  assign act_in = {bus_rx_event, bus_tx_event, serial_rx_event, serial_tx_event};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_led
      reg s1;
      reg s2;
      reg [31:0] cnt;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          cnt <= 32'h00000000;
        end else begin
          s1 <= act_in[gi];
          s2 <= s1;
          if (s2) begin
            cnt <= LED_CYCLES;
          end else if (cnt != 32'h00000000) begin
            cnt <= cnt - 32'h00000001;
          end
        end
      end
      assign act_led[gi] = (cnt != 32'h00000000);
    end
  endgenerate
  assign serial_tx_indicator = act_led[0];
  assign serial_rx_indicator = act_led[1];
  assign bus_tx_indicator = act_led[2];
  assign bus_rx_indicator = act_led[3];
endmodule
`default_nettype wire

//--- sccc_defs.vh
// constants for the serial to bus converter configuration block
`ifndef SCCC_DEFS_VH
`define SCCC_DEFS_VH
`define SCCC_ADDR_W 12
`define SCCC_OFF_CTRL 12'h000
`define SCCC_OFF_BAUD 12'h004
`define SCCC_OFF_BUSRATE 12'h008
`define SCCC_OFF_TXID 12'h00c
`define SCCC_OFF_ACC 12'h010
`define SCCC_OFF_MASK 12'h014
`define SCCC_OFF_MARK 12'h018
`define SCCC_OFF_STATUS 12'h01c
`define SCCC_OFF_COMMIT 12'h020
`define SCCC_MODE_PLAIN 2'h0
`define SCCC_MODE_MARK 2'h1
`define SCCC_MODE_MODBUS 2'h2
`define SCCC_CTRL_MODE_LO 0
`define SCCC_CTRL_MODE_HI 1
`define SCCC_CTRL_INFO 2
`define SCCC_CTRL_IDENT 3
`define SCCC_CTRL_EXT 4
`define SCCC_CTRL_CMASK 5
`define SCCC_BAUD_MIN 32'd1200
`define SCCC_BAUD_MAX 32'd115200
`define SCCC_BAUD_DEF 32'd9600
`define SCCC_BUSRATE_MIN 32'd5000
`define SCCC_BUSRATE_MAX 32'd1000000
`define SCCC_BUSRATE_DEF 32'd125000
`define SCCC_CTRL_DEF 6'h00
`define SCCC_STD_MASK 32'h000007ff
`define SCCC_EXT_MASK 32'h1fffffff
`define SCCC_IDENT_BYTES 3'h4
`define SCCC_MARK_DEF 8'h14
`define SCCC_LED_MS 32'd50
`define SCCC_CLK_KHZ 32'd250000
`define SCCC_STRAP_WAIT 2'h2
`define SCCC_MODE_BAD 2'h3
`define SCCC_COMMIT_BIT 0
`define SCCC_MARK_START_HI 3
`define SCCC_MARK_LEN_LO 4
`define SCCC_MARK_LEN_HI 7
`endif

//--- sccc_properties.sv
// port assertions for the converter configuration block
`timescale 1ns/1ps
`default_nettype none
module sccc_properties (
  input wire pclk,
  input wire presetn,
  input wire rx_ident_valid,
  input wire rx_accept,
  input wire rx_reject,
  input wire [1:0] conv_mode,
  input wire emit_info,
  input wire emit_ident,
  input wire [2:0] header_len,
  input wire ext_frame,
  input wire [31:0] tx_ident,
  input wire [31:0] serial_baud,
  input wire config_mode,
  input wire power_indicator,
  input wire bus_rx_event,
  input wire bus_rx_indicator
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence lit_long;
    bus_rx_indicator [*8];
  endsequence
  sequence seen_event;
    $past(bus_rx_event) || $past(bus_rx_event, 2) || $past(bus_rx_event, 3);
  endsequence
  chk_filter_answer: assert property (rx_ident_valid |=> rx_accept != rx_reject)
    else $error("filter answer missing");
  chk_filter_cause: assert property ((rx_accept || rx_reject) |-> $past(rx_ident_valid))
    else $error("filter answer without request");
  chk_std_trunc: assert property (!ext_frame |-> tx_ident[31:11] == 21'h0)
    else $error("standard identifier too wide");
  chk_ext_trunc: assert property (ext_frame |-> tx_ident[31:29] == 3'h0)
    else $error("extended identifier too wide");
  chk_header_len: assert property (1'b1 |=> header_len == {$past(emit_ident), 1'b0, $past(emit_info)})
    else $error("header length wrong");
  chk_emit_plain: assert property ((emit_info || emit_ident) |-> conv_mode == 2'h0)
    else $error("header outside plain mode");
  chk_mode_legal: assert property (conv_mode != 2'h3)
    else $error("illegal conversion mode");
  chk_power_on: assert property (power_indicator)
    else $error("power indicator dark");
  chk_led_stretch: assert property ($rose(bus_rx_indicator) |-> lit_long)
    else $error("indicator pulse too short");
  chk_led_cause: assert property ($rose(bus_rx_indicator) |-> seen_event)
    else $error("indicator without activity");
  chk_baud_range: assert property (serial_baud >= 32'd1200 && serial_baud <= 32'd115200)
    else $error("baud out of range");
  chk_mode_kept: assert property ($past(config_mode) |-> config_mode)
    else $error("configuration mode lost");
endmodule
bind sccc_top sccc_properties u_chk (.pclk(pclk), .presetn(presetn),
  .rx_ident_valid(rx_ident_valid), .rx_accept(rx_accept), .rx_reject(rx_reject),
  .conv_mode(conv_mode), .emit_info(emit_info), .emit_ident(emit_ident),
  .header_len(header_len), .ext_frame(ext_frame), .tx_ident(tx_ident),
  .serial_baud(serial_baud), .config_mode(config_mode), .power_indicator(power_indicator),
  .bus_rx_event(bus_rx_event), .bus_rx_indicator(bus_rx_indicator));
`default_nettype wire

//--- sccc_far.sv
// far side model: bus receiver, serial framer, activity sources
`timescale 1ns/1ps
`default_nettype none
module sccc_far (
  input wire logic pclk,
  output logic [31:0] rx_ident,
  output logic rx_ident_valid,
  output logic [7:0] rx_frame_info,
  output logic [7:0] mark_frame_byte,
  output logic mark_frame_valid,
  output logic mark_frame_start,
  output logic [3:0] events
);
  initial begin
    rx_ident = 32'h0;
    rx_ident_valid = 1'b0;
    rx_frame_info = 8'h0;
    mark_frame_byte = 8'h0;
    mark_frame_valid = 1'b0;
    mark_frame_start = 1'b0;
    events = 4'h0;
  end
  task automatic send_id(input logic [31:0] id);
    @(posedge pclk);
    rx_ident <= id;
    rx_frame_info <= id[7:0];
    rx_ident_valid <= 1'b1;
    @(posedge pclk);
    rx_ident_valid <= 1'b0;
    rx_ident <= ~id;
  endtask
  // gap plus one idle cycles between bytes for a slow sender
  task automatic frame(input logic [23:0] b, input int gap);
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      mark_frame_byte <= b[23 - 8 * i -: 8];
      mark_frame_valid <= 1'b1;
      mark_frame_start <= (i == 0);
      @(posedge pclk);
      mark_frame_valid <= 1'b0;
      mark_frame_start <= 1'b0;
      mark_frame_byte <= ~b[23 - 8 * i -: 8];
      repeat (gap) @(posedge pclk);
    end
  endtask
  task automatic act(input logic [3:0] m);
    @(posedge pclk);
    events <= m;
    @(posedge pclk);
    events <= 4'h0;
  endtask
endmodule
`default_nettype wire

//--- serial_can_converter_config_bench.sv
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
`default_nettype none
`include "sccc_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module serial_can_converter_config_bench;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] txid, rxid, tx;
    logic acc;
    logic [2:0] hdr;
  } sccc_row_t;
  sccc_row_t rows [6] = '{'{8'h00, 32'hffffffff, 32'h806, 32'h7ff, 1'b1, 3'd0},
    '{8'h0c, 32'h0a, 32'h7, 32'h0a, 1'b0, 3'd5},
    '{8'h14, 32'hffffffff, 32'h20000006, 32'h1fffffff, 1'b1, 3'd1},
    '{8'h18, 32'h12345678, 32'h806, 32'h12345678, 1'b0, 3'd4},
    '{8'h0e, 32'h0, 32'h6, 32'h0, 1'b1, 3'd0},
    '{8'h20, 32'h7ff, 32'h123, 32'h7ff, 1'b1, 3'd0}};
  logic pclk, presetn, psel, penable, pwrite, strap_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  wire [31:0] prdata, tx_ident, serial_baud, bus_rate, rx_ident;
  wire pready, rx_accept, ext_frame, config_mode, power_indicator, iv, mv, ms;
  wire rx_reject, emit_info, emit_ident, pslverr;
  wire [7:0] info, mbyte, header_info;
  wire [1:0] conv_mode;
  wire [2:0] header_len;
  wire [3:0] ind, ev;
  int mismatches, comparisons, n, cnt;
  sccc_far u_far (.pclk(pclk), .rx_ident(rx_ident), .rx_ident_valid(iv),
    .rx_frame_info(info), .mark_frame_byte(mbyte), .mark_frame_valid(mv),
    .mark_frame_start(ms), .events(ev));
  sccc_top #(.LED_CYCLES(32'd20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_strap_n(strap_n), .serial_tx_event(ev[0]),
    .serial_rx_event(ev[1]), .bus_tx_event(ev[2]), .bus_rx_event(ev[3]),
    .rx_ident(rx_ident), .rx_ident_valid(iv), .rx_frame_info(info),
    .mark_frame_byte(mbyte), .mark_frame_valid(mv), .mark_frame_start(ms),
    .rx_accept(rx_accept), .rx_reject(rx_reject), .conv_mode(conv_mode),
    .emit_info(emit_info), .emit_ident(emit_ident), .header_len(header_len),
    .header_info(header_info), .ext_frame(ext_frame),
    .tx_ident(tx_ident), .serial_baud(serial_baud), .bus_rate(bus_rate),
    .config_mode(config_mode), .power_indicator(power_indicator),
    .serial_tx_indicator(ind[0]), .serial_rx_indicator(ind[1]),
    .bus_tx_indicator(ind[2]), .bus_rx_indicator(ind[3]));
  task conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      conclude();
    end
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic commit;
    bus(1'b1, `SCCC_OFF_COMMIT, 32'h1);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, strap_n} = 49'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b1, `SCCC_OFF_BAUD, 32'd1200);
    commit();
    `CHK(config_mode, 1'b0)
    `CHK(serial_baud, `SCCC_BAUD_DEF)
    `CHK(pslverr, 1'b0)
    `CHK(bus_rate, `SCCC_BUSRATE_DEF)
    `CHK(power_indicator, 1'b1)
    @(posedge pclk);
    presetn <= 1'b0;
    strap_n <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    bus(1'b0, `SCCC_OFF_STATUS, 32'h0);
    `CHK(rdata[0], 1'b1)
    bus(1'b0, 12'h100, 32'h0);
    `CHK(rdata, 32'h0)
    bus(1'b1, `SCCC_OFF_ACC, 32'h6);
    bus(1'b1, `SCCC_OFF_MASK, 32'hffffffff);
    foreach (rows[i]) begin
      bus(1'b1, `SCCC_OFF_CTRL, {24'h0, rows[i].ctrl});
      bus(1'b1, `SCCC_OFF_TXID, rows[i].txid);
      commit();
      `CHK(conv_mode, rows[i].ctrl[1:0])
      `CHK(tx_ident, rows[i].tx)
      `CHK(header_len, rows[i].hdr)
      `CHK(ext_frame, rows[i].ctrl[4])
      `CHK(emit_info, rows[i].hdr[0])
      `CHK(emit_ident, rows[i].hdr[2])
      u_far.send_id(rows[i].rxid);
      @(negedge pclk);
      `CHK(rx_accept, rows[i].acc)
      `CHK(rx_reject, !rows[i].acc)
      `CHK(header_info, rows[i].rxid[7:0])
    end
    bus(1'b1, `SCCC_OFF_CTRL, 32'h3);
    bus(1'b1, `SCCC_OFF_BAUD, 32'd1200);
    bus(1'b1, `SCCC_OFF_BAUD, 32'd1199);
    bus(1'b1, `SCCC_OFF_BUSRATE, 32'd1000000);
    bus(1'b1, `SCCC_OFF_BUSRATE, 32'd1000001);
    commit();
    `CHK(conv_mode, 2'h0)
    `CHK(serial_baud, 32'd1200)
    `CHK(bus_rate, 32'd1000000)
    bus(1'b1, `SCCC_OFF_MARK, 32'h20);
    bus(1'b1, `SCCC_OFF_CTRL, 32'h1);
    commit();
    u_far.frame(24'h012345, 2);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    `CHK(tx_ident, 32'h123)
    for (int k = 0; k < 4; k++) begin
      u_far.act(4'h1 << k);
      n = 0;
      while (ind[k] !== 1'b1 && n < 10) begin @(negedge pclk); n++; end
      cnt = 0;
      while (ind[k] === 1'b1 && cnt < 100) begin @(negedge pclk); cnt++; end
      `CHK(cnt >= 20 && cnt <= 21, 1'b1)
    end
    // second event mid-pulse must restart the stretch
    u_far.act(4'h8);
    repeat (10) @(posedge pclk);
    u_far.act(4'h8);
    repeat (17) @(posedge pclk);
    @(negedge pclk);
    `CHK(ind[3], 1'b1)
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    `CHK(ind[3], 1'b0)
    conclude();
  end
endmodule
`default_nettype wire
